// [core/battery_capacity_gauge.sv]
/*
 * Capacity accounting, calibration learning and charge control of a battery gauge.
 * Assumes configuration and measurements arrive settled on ref_clk; VFC pulses are
 * asynchronous; the broadcast engine runs on its own link clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gauge_consts.svh"
module battery_capacity_gauge #(
	parameter int TICKS_PER_SEC = `SECOND_NS / `CLK_PERIOD_NS,
	parameter logic [15:0] INIT_FULL_CAPACITY = 16'd2000
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic smb_clk,
	input wire gauge_pkg::gauge_cfg_t cfg,
	input wire gauge_pkg::gauge_meas_t meas,
	input wire logic chg_pulse,
	input wire logic dsg_pulse,
	input wire logic [7:0] reg_cmd,
	output logic [15:0] reg_rdata,
	output logic nv_save,
	output logic [15:0] nv_full_capacity,
	output logic valid_discharge_flag,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic nack_seen
);
	import gauge_pkg::*;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	logic [2:0] chg_sync_ff, nxt_chg_sync, dsg_sync_ff, nxt_dsg_sync;
	logic [23:0] rm_ff, nxt_rm, dcr_ff, nxt_dcr, chg_acc_ff, nxt_chg_acc, sd_total_ff, nxt_sd_total;
	logic [15:0] fcc_ff, nxt_fcc, max_err_ff, nxt_max_err, learned_ff, nxt_learned, rdata_ff, nxt_rdata;
	logic vdq_ff, nxt_vdq, learn_pend_ff, nxt_learn_pend, first_end_discharge_threshold_ff, nxt_first_end_discharge_threshold, nv_save_ff, nxt_nv_save;
	logic [31:0] tick_ff, nxt_tick, sd_sec_ff, nxt_sd_sec;
	logic [3:0] bc_sec_ff, nxt_bc_sec;
	logic oc_ff, nxt_oc, req_tgl_ff, nxt_req_tgl;
	logic [1:0] ack_sync_ff, nxt_ack_sync;
	bcast_t bc_ff, nxt_bc;
	logic ack_tgl;

	logic chg_pkt, dsg_pkt, accept, sec_pulse, sd_evt, bc_evt, busy;
	logic first_end_discharge_threshold_now, first_end_discharge_threshold_rise, final_end_discharge_threshold_now, vdq_set, valid_chg, oc_detect;
	logic [7:0] eff_base, eff_drop, eff;
	logic [31:0] rsoc_w, low_mah, chg_amt_w, sd_base, sd_interval, cand_w, cur_abs;
	logic [23:0] low_u, sd_amt;
	logic [2:0] band;
	logic [15:0] status_w, req_cur;

	// Positive and negative VFC pulses are edge-detected after a two-stage synchroniser
	assign chg_pkt = chg_sync_ff[1] && !chg_sync_ff[2];
	assign dsg_pkt = dsg_sync_ff[1] && !dsg_sync_ff[2];
	assign accept = meas.sense_uv >= cfg.filter_uv;
	assign sec_pulse = (tick_ff == 32'(TICKS_PER_SEC - 1));
	assign first_end_discharge_threshold_now = meas.voltage_mv < cfg.first_end_discharge_threshold;
	assign first_end_discharge_threshold_rise = first_end_discharge_threshold_now && !first_end_discharge_threshold_ff;
	assign final_end_discharge_threshold_now = meas.voltage_mv <= cfg.final_end_discharge_threshold;
	assign valid_chg = chg_acc_ff >= 24'(`VALID_CHARGE_MAH * `UNITS_PER_MAH);

	always_comb begin
		rsoc_w = (fcc_ff == 16'h0000) ? 32'd0 : (32'(rm_ff[23:8]) * `PERCENT_FULL) / 32'(fcc_ff);
		eff_base = (rsoc_w < 32'(cfg.full_charge_percentage)) ?
			cfg.high_efficiency_factor : cfg.low_efficiency_factor;
		eff_drop = 8'd0;
		if (!cfg.chemistry_bit && meas.temp_c > `TEMP_HOT_C) begin
			eff_drop = `EFF_DROP_HOT;
		end else if (!cfg.chemistry_bit && meas.temp_c >= `TEMP_WARM_C) begin
			eff_drop = `EFF_DROP_WARM;
		end
		eff = (eff_base > eff_drop) ? eff_base - eff_drop : 8'd0;
		chg_amt_w = (32'(cfg.integration_gain) * 32'(eff)) / `PERCENT_FULL;
		low_mah = (32'(fcc_ff) * 32'(cfg.battery_low_percentage)) / `PERCENT_FULL;
		low_u = {low_mah[15:0], 8'h00};
		if (meas.temp_c < 8'sd0) begin
			band = 3'd0;
		end else if (meas.temp_c >= 8'(`TEMP_BAND_C * 8'sd7)) begin
			band = `TEMP_BAND_MAX;
		end else begin
			band = 3'(meas.temp_c / `TEMP_BAND_C);
		end
		sd_base = `SD_BASE_S << cfg.self_discharge_rate_setting;
		// Each band above the reference halves the interval, which doubles the effective rate
		sd_interval = (band >= `TEMP_BAND_REF) ? sd_base >> (band - `TEMP_BAND_REF) :
			sd_base << (`TEMP_BAND_REF - band);
		if (sd_interval == 32'd0) begin
			sd_interval = 32'd1;
		end
		sd_evt = sec_pulse && meas.discharging && (sd_sec_ff + 32'd1 >= sd_interval);
		sd_amt = rm_ff >> 8;
		cand_w = low_mah + 32'(dcr_ff[23:8]);
	end

	always_comb begin
		nxt_chg_sync = {chg_sync_ff[1:0], chg_pulse};
		nxt_dsg_sync = {dsg_sync_ff[1:0], dsg_pulse};
		nxt_tick = sec_pulse ? 32'd0 : tick_ff + 32'd1;
		nxt_sd_sec = sd_evt || !meas.discharging ? 32'd0 : (sec_pulse ? sd_sec_ff + 32'd1 : sd_sec_ff);
		nxt_rm = rm_ff;
		nxt_dcr = dcr_ff;
		nxt_chg_acc = chg_acc_ff;
		nxt_sd_total = sd_total_ff;
		nxt_fcc = fcc_ff;
		nxt_max_err = max_err_ff;
		nxt_learned = learned_ff;
		nxt_learn_pend = learn_pend_ff;
		nxt_vdq = vdq_ff;
		nxt_first_end_discharge_threshold = first_end_discharge_threshold_now;
		nxt_nv_save = 1'b0;
		vdq_set = 1'b0;
		if (sd_evt) begin
			nxt_rm = nxt_rm - sd_amt;
			nxt_sd_total = sd_total_ff + sd_amt;
		end
		if (chg_pkt && accept) begin
			nxt_rm = (32'(nxt_rm) + chg_amt_w > 32'h00ff_ffff) ? 24'hff_ffff :
				nxt_rm + chg_amt_w[23:0];
			nxt_chg_acc = chg_acc_ff + chg_amt_w[23:0];
			vdq_set = (nxt_rm[23:8] == fcc_ff);
		end else if (dsg_pkt && accept) begin
			nxt_chg_acc = 24'd0;
			if (vdq_ff) begin
				nxt_dcr = dcr_ff + 24'(cfg.integration_gain);
			end
			nxt_rm = (nxt_rm < 24'(cfg.integration_gain)) ? 24'd0 :
				nxt_rm - 24'(cfg.integration_gain);
			if (!first_end_discharge_threshold_now && nxt_rm < low_u) begin
				// Capacity parks at the low level so the learned span stays honest
				nxt_rm = (rm_ff > low_u) ? low_u : rm_ff;
			end
		end
		if (first_end_discharge_threshold_rise) begin
			if (nxt_rm > low_u) begin
				nxt_rm = low_u;
			end
			if (vdq_ff) begin
				nxt_learned = (cand_w[15:0] + `LEARN_DECREASE_MAH < fcc_ff) ?
					fcc_ff - `LEARN_DECREASE_MAH : cand_w[15:0];
				nxt_learn_pend = 1'b1;
				nxt_chg_acc = 24'd0;
			end
			if (32'(meas.voltage_mv) + 32'(`FIRST_END_DISCHARGE_THRESHOLD_FAST_DROP_MV) <=
				32'(cfg.first_end_discharge_threshold)) begin
				nxt_vdq = 1'b0;
			end
		end
		if (final_end_discharge_threshold_now) begin
			nxt_rm = 24'd0;
		end
		if (valid_chg || sd_total_ff >= 24'(`SELF_DIS_LIMIT_MAH * `UNITS_PER_MAH)) begin
			nxt_vdq = 1'b0;
		end
		if (valid_chg && learn_pend_ff) begin
			nxt_fcc = learned_ff;
			nxt_learn_pend = 1'b0;
			nxt_chg_acc = 24'd0;
			if (fcc_ff > `LEARN_SAVE_MIN_MAH && fcc_ff <= learned_ff + `LEARN_SAVE_MIN_MAH) begin
				nxt_max_err = `MAX_ERROR_LEARNED;
				nxt_nv_save = 1'b1;
			end
		end
		if (meas.low_temperature_fault) begin
			nxt_vdq = 1'b0;
		end
		if (vdq_set) begin
			nxt_vdq = 1'b1;
			// The charge that filled the pack must not count as the clearing charge
			nxt_chg_acc = 24'd0;
			nxt_dcr = 24'd0;
			nxt_sd_total = 24'd0;
		end
		case (reg_cmd)
			`CMD_MAX_ERROR: nxt_rdata = max_err_ff;
			`CMD_REL_CHARGE: nxt_rdata = rsoc_w[15:0];
			`CMD_REMAINING: nxt_rdata = rm_ff[23:8];
			`CMD_FULL_CAP: nxt_rdata = fcc_ff;
			default: nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			chg_sync_ff <= 3'b000;
			dsg_sync_ff <= 3'b000;
			tick_ff <= 32'd0;
			sd_sec_ff <= 32'd0;
			rm_ff <= 24'd0;
			dcr_ff <= 24'd0;
			chg_acc_ff <= 24'd0;
			sd_total_ff <= 24'd0;
			fcc_ff <= INIT_FULL_CAPACITY;
			max_err_ff <= `MAX_ERROR_RESET;
			learned_ff <= 16'h0000;
			learn_pend_ff <= 1'b0;
			vdq_ff <= 1'b0;
			first_end_discharge_threshold_ff <= 1'b0;
			nv_save_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end else begin
			chg_sync_ff <= nxt_chg_sync;
			dsg_sync_ff <= nxt_dsg_sync;
			tick_ff <= nxt_tick;
			sd_sec_ff <= nxt_sd_sec;
			rm_ff <= nxt_rm;
			dcr_ff <= nxt_dcr;
			chg_acc_ff <= nxt_chg_acc;
			sd_total_ff <= nxt_sd_total;
			fcc_ff <= nxt_fcc;
			max_err_ff <= nxt_max_err;
			learned_ff <= nxt_learned;
			learn_pend_ff <= nxt_learn_pend;
			vdq_ff <= nxt_vdq;
			first_end_discharge_threshold_ff <= nxt_first_end_discharge_threshold;
			nv_save_ff <= nxt_nv_save;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign nv_save = nv_save_ff;
	assign nv_full_capacity = fcc_ff;
	assign valid_discharge_flag = vdq_ff;

	// Charge control: overcurrent latch and ten-second broadcast handoff
	assign busy = req_tgl_ff != ack_sync_ff[1];
	assign bc_evt = sec_pulse && (bc_sec_ff == `BCAST_PERIOD_S - 4'd1);
	assign cur_abs = meas.current_ma[15] ? 32'd0 : 32'(meas.current_ma);

	always_comb begin
		if (cfg.nominal_charge_current >= 16'(`OC_KNEE_MA)) begin
			oc_detect = cur_abs * `OC_RATIO_DEN > 32'(cfg.nominal_charge_current) * `OC_RATIO_NUM;
		end else begin
			oc_detect = cur_abs > 32'(cfg.nominal_charge_current) + `OC_MARGIN_MA;
		end
		nxt_oc = oc_ff;
		if (oc_detect) begin
			nxt_oc = 1'b1;
		end else if (meas.current_ma < `OC_CLEAR_MA) begin
			nxt_oc = 1'b0;
		end
		status_w = meas.battery_status;
		status_w[`TCA_BIT] = status_w[`TCA_BIT] | oc_ff;
		req_cur = (oc_ff || |status_w[15:`CHARGER_ALARM_LSB]) ? 16'h0000 :
			cfg.nominal_charge_current;
		nxt_ack_sync = {ack_sync_ff[0], ack_tgl};
		nxt_bc_sec = bc_evt ? 4'd0 : (sec_pulse ? bc_sec_ff + 4'd1 : bc_sec_ff);
		nxt_bc = bc_ff;
		nxt_req_tgl = req_tgl_ff;
		// A broadcast still in flight makes the next slot skip rather than queue
		if (bc_evt && cfg.charge_control_enable && !busy) begin
			nxt_bc.cur = req_cur;
			nxt_bc.volt = cfg.charge_voltage;
			nxt_bc.status = status_w;
			nxt_bc.alarm = |status_w[15:`CHARGER_ALARM_LSB];
			nxt_req_tgl = !req_tgl_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			oc_ff <= 1'b0;
			ack_sync_ff <= 2'b00;
			bc_sec_ff <= 4'd0;
			bc_ff <= '0;
			req_tgl_ff <= 1'b0;
		end else begin
			oc_ff <= nxt_oc;
			ack_sync_ff <= nxt_ack_sync;
			bc_sec_ff <= nxt_bc_sec;
			bc_ff <= nxt_bc;
			req_tgl_ff <= nxt_req_tgl;
		end
	end

	smbus_broadcaster u_link (
		.smb_clk(smb_clk),
		.reset_n(reset_n),
		.req_tgl(req_tgl_ff),
		.msg(bc_ff),
		.ack_tgl(ack_tgl),
		.scl_in(scl_in),
		.scl_out(scl_out),
		.scl_oe(scl_oe),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.nack_seen(nack_seen)
	);

	AST_FILTER_HOLDS: assert property (
		((chg_pkt || dsg_pkt) && !accept && !sd_evt && !first_end_discharge_threshold_rise && !final_end_discharge_threshold_now) |=> $stable(rm_ff))
		else $error("filtered packet changed capacity");
	AST_DISCHARGE_STEP: assert property (
		(dsg_pkt && accept && first_end_discharge_threshold_ff && first_end_discharge_threshold_now && !sd_evt && !final_end_discharge_threshold_now &&
		rm_ff >= 24'(cfg.integration_gain)) |=>
		rm_ff == $past(rm_ff) - 24'($past(cfg.integration_gain)))
		else $error("discharge packet step wrong");
	AST_FINAL_ZERO: assert property (final_end_discharge_threshold_now |=> rm_ff == 24'd0)
		else $error("final threshold did not zero capacity");
	AST_FIRST_CLAMP: assert property (
		(first_end_discharge_threshold_rise && !final_end_discharge_threshold_now && !chg_pkt) |=> rm_ff <= $past(low_u))
		else $error("first threshold did not write capacity down");
	AST_VDQ_CLEAR: assert property (
		(valid_chg && !vdq_set) |=> !vdq_ff)
		else $error("valid charge did not clear valid-discharge");
	AST_LEARN_SAVE: assert property (
		nv_save_ff |-> (max_err_ff == `MAX_ERROR_LEARNED && $past(learn_pend_ff) && !learn_pend_ff))
		else $error("save without learned update");
	AST_OC_REQUEST: assert property (
		(bc_evt && cfg.charge_control_enable && !busy && oc_ff) |=>
		(bc_ff.cur == 16'h0000 && bc_ff.status[`TCA_BIT] && busy))
		else $error("overcurrent broadcast not zeroed");
	AST_BCAST_ENABLE: assert property (
		!cfg.charge_control_enable |=> $stable(req_tgl_ff))
		else $error("broadcast while charge control disabled");
	AST_SD_GATE: assert property (
		(!meas.discharging && !chg_pkt && !dsg_pkt && !first_end_discharge_threshold_rise && !final_end_discharge_threshold_now) |=> $stable(rm_ff))
		else $error("capacity moved while not discharging");
	COV_VDQ_SET: cover property ($rose(vdq_ff));
	COV_LEARN: cover property ($rose(nv_save_ff));
	COV_OC: cover property ($rose(oc_ff) ##[1:200] $fell(oc_ff));
endmodule : battery_capacity_gauge
`default_nettype wire

// [shared/gauge_consts.svh]
/*
 * Constants for the capacity gauge: command codes, field positions, limits and timing.
 * Assumes inclusion by the gauge core and the link engine, the design files that need a figure.
 */
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH

`define CMD_MAX_ERROR 8'h0c
`define CMD_REL_CHARGE 8'h0d
`define CMD_REMAINING 8'h0f
`define CMD_FULL_CAP 8'h10
`define CMD_CHG_CURRENT 8'h14
`define CMD_CHG_VOLTAGE 8'h15
`define CMD_ALARM_WARNING 8'h16
`define CHARGER_ADDR_BYTE 8'h12
`define UNITS_PER_MAH 32'd256
`define VALID_CHARGE_MAH 32'd10
`define SELF_DIS_LIMIT_MAH 32'd256
`define LEARN_DECREASE_MAH 16'd256
`define LEARN_SAVE_MIN_MAH 16'd256
`define FIRST_END_DISCHARGE_THRESHOLD_FAST_DROP_MV 17'd256
`define MAX_ERROR_LEARNED 16'h0002
`define MAX_ERROR_RESET 16'h0064
`define PERCENT_FULL 32'd100
`define EFF_DROP_WARM 8'd2
`define EFF_DROP_HOT 8'd5
`define TEMP_WARM_C 8'sd30
`define TEMP_HOT_C 8'sd40
`define TEMP_BAND_C 8'sd10
`define TEMP_BAND_REF 3'd2
`define TEMP_BAND_MAX 3'd7
`define SD_BASE_S 32'd640
`define BCAST_PERIOD_S 4'd10
`define OC_KNEE_MA 32'd1024
`define OC_MARGIN_MA 32'd256
`define OC_CLEAR_MA 16'sd256
`define OC_RATIO_NUM 32'd5
`define OC_RATIO_DEN 32'd4
`define TCA_BIT 14
`define CHARGER_ALARM_LSB 10
`define CLK_PERIOD_NS 32'd20
`define SECOND_NS 32'd1000000000

`endif

// [shared/gauge_pkg.sv]
/*
 * Types shared by the gauge core and its link-side broadcaster.
 * Assumes the constants header sits beside it on the include path.
 */
package gauge_pkg;
	typedef struct packed {
		logic [15:0] filter_uv;
		logic [15:0] integration_gain;
		logic [7:0] full_charge_percentage;
		logic [7:0] high_efficiency_factor;
		logic [7:0] low_efficiency_factor;
		logic chemistry_bit;
		logic [3:0] self_discharge_rate_setting;
		logic [15:0] first_end_discharge_threshold;
		logic [15:0] final_end_discharge_threshold;
		logic [7:0] battery_low_percentage;
		logic charge_control_enable;
		logic [15:0] nominal_charge_current;
		logic [15:0] charge_voltage;
	} gauge_cfg_t;

	typedef struct packed {
		logic [15:0] sense_uv;
		logic [15:0] voltage_mv;
		logic signed [7:0] temp_c;
		logic signed [15:0] current_ma;
		logic discharging;
		logic low_temperature_fault;
		logic [15:0] battery_status;
	} gauge_meas_t;

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] volt;
		logic [15:0] status;
		logic alarm;
	} bcast_t;
endpackage : gauge_pkg

// [core/smbus_broadcaster.sv]
/*
 * SMBus master-write engine on the link clock: sends current and voltage words, and the alarm word only when msg.alarm is set.
 * Assumes the request word is held stable from its toggle until the ack toggle returns.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gauge_consts.svh"
module smbus_broadcaster (
	input wire logic smb_clk,
	input wire logic reset_n,
	input wire logic req_tgl,
	input wire gauge_pkg::bcast_t msg,
	output logic ack_tgl,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic nack_seen
);
	import gauge_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_STOP, S_DONE} bst_t;
	bst_t st_ff, nxt_st;
	logic [1:0] req_sync_ff, nxt_req_sync, scl_sync_ff, nxt_scl_sync, sda_sync_ff, nxt_sda_sync;
	logic seen_ff, nxt_seen, ack_ff, nxt_ack, scl_low_ff, nxt_scl_low, sda_low_ff, nxt_sda_low;
	logic nack_ff, nxt_nack;
	logic [1:0] ph_ff, nxt_ph, byte_ff, nxt_byte, msg_ff, nxt_msg;
	logic [3:0] bit_ff, nxt_bit;
	logic [7:0] cur_byte;
	logic [15:0] word;

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_low_ff;
	assign sda_oe = sda_low_ff;
	assign ack_tgl = ack_ff;
	assign nack_seen = nack_ff;

	always_comb begin
		word = (msg_ff == 2'd0) ? msg.cur : (msg_ff == 2'd1) ? msg.volt : msg.status;
		case (byte_ff)
			2'd0: cur_byte = `CHARGER_ADDR_BYTE;
			2'd1: cur_byte = (msg_ff == 2'd0) ? `CMD_CHG_CURRENT :
				(msg_ff == 2'd1) ? `CMD_CHG_VOLTAGE : `CMD_ALARM_WARNING;
			2'd2: cur_byte = word[7:0];
			default: cur_byte = word[15:8];
		endcase
	end

	always_comb begin
		nxt_req_sync = {req_sync_ff[0], req_tgl};
		nxt_scl_sync = {scl_sync_ff[0], scl_in};
		nxt_sda_sync = {sda_sync_ff[0], sda_in};
		nxt_st = st_ff;
		nxt_seen = seen_ff;
		nxt_ack = ack_ff;
		nxt_scl_low = scl_low_ff;
		nxt_sda_low = sda_low_ff;
		nxt_nack = nack_ff;
		nxt_ph = ph_ff;
		nxt_byte = byte_ff;
		nxt_msg = msg_ff;
		nxt_bit = bit_ff;
		case (st_ff)
			S_IDLE: begin
				if (req_sync_ff[1] != seen_ff) begin
					nxt_seen = req_sync_ff[1];
					nxt_msg = 2'd0;
					nxt_nack = 1'b0;
					nxt_st = S_START;
				end
			end
			S_START: begin
				nxt_sda_low = 1'b1;
				nxt_ph = 2'd0;
				nxt_bit = 4'd0;
				nxt_byte = 2'd0;
				nxt_st = S_BIT;
			end
			S_BIT: begin
				nxt_ph = ph_ff + 2'd1;
				case (ph_ff)
					2'd0: begin
						nxt_scl_low = 1'b1;
						nxt_sda_low = (bit_ff == 4'd8) ? 1'b0 : !cur_byte[3'd7 - bit_ff[2:0]];
					end
					2'd1: nxt_scl_low = 1'b0;
					2'd2: begin
						// A slow slave may hold SCL low; wait for it before sampling
						if (!scl_sync_ff[1]) begin
							nxt_ph = ph_ff;
						end else if (bit_ff == 4'd8 && sda_sync_ff[1]) begin
							nxt_nack = 1'b1;
						end
					end
					default: begin
						nxt_scl_low = 1'b1;
						nxt_bit = bit_ff + 4'd1;
						if (bit_ff == 4'd8) begin
							nxt_bit = 4'd0;
							nxt_byte = byte_ff + 2'd1;
							if (byte_ff == 2'd3) begin
								nxt_st = S_STOP;
							end
						end
					end
				endcase
			end
			S_STOP: begin
				nxt_ph = ph_ff + 2'd1;
				case (ph_ff)
					2'd0: nxt_sda_low = 1'b1;
					2'd1: nxt_scl_low = 1'b0;
					2'd2: nxt_sda_low = 1'b0;
					default: begin
						nxt_msg = msg_ff + 2'd1;
						nxt_st = ((msg_ff == 2'd1 && !msg.alarm) || msg_ff == 2'd2) ? S_DONE : S_START;
					end
				endcase
			end
			S_DONE: begin
				nxt_ack = seen_ff;
				nxt_st = S_IDLE;
			end
			default: nxt_st = S_IDLE;
		endcase
	end

	always_ff @(posedge smb_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= S_IDLE;
			req_sync_ff <= 2'b00;
			scl_sync_ff <= 2'b11;
			sda_sync_ff <= 2'b11;
			seen_ff <= 1'b0;
			ack_ff <= 1'b0;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			nack_ff <= 1'b0;
			ph_ff <= 2'd0;
			byte_ff <= 2'd0;
			msg_ff <= 2'd0;
			bit_ff <= 4'd0;
		end else begin
			st_ff <= nxt_st;
			req_sync_ff <= nxt_req_sync;
			scl_sync_ff <= nxt_scl_sync;
			sda_sync_ff <= nxt_sda_sync;
			seen_ff <= nxt_seen;
			ack_ff <= nxt_ack;
			scl_low_ff <= nxt_scl_low;
			sda_low_ff <= nxt_sda_low;
			nack_ff <= nxt_nack;
			ph_ff <= nxt_ph;
			byte_ff <= nxt_byte;
			msg_ff <= nxt_msg;
			bit_ff <= nxt_bit;
		end
	end
endmodule : smbus_broadcaster
`default_nettype wire

// [verif/charger_model.sv]
/* Charger model on the two-wire link: acks every byte unless refuse is set, keeps the last four bytes seen.
   Assumes wired-and lines with pull-ups built by the bench from all enables. */
`timescale 1ns/10ps
`default_nettype none
module charger_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic refuse,
	output logic ack_oe,
	output logic [31:0] last4,
	output logic [15:0] nbytes
);
	logic [3:0] nbit;
	logic [7:0] sh;
	initial begin
		ack_oe = 1'b0;
		last4 = 32'h0;
		nbytes = 16'h0;
		nbit = 4'h0;
		sh = 8'h00;
	end
	// A start realigns byte framing, so a missed bit cannot shift later bytes
	always @(negedge sda) if (scl) nbit = 4'h0;
	always @(posedge scl) begin
		if (nbit == 4'h8) begin
			nbit = 4'h0;
		end else begin
			sh = {sh[6:0], sda};
			nbit = nbit + 4'h1;
			if (nbit == 4'h8) begin
				last4 = {last4[23:0], sh};
				nbytes = nbytes + 16'h1;
			end
		end
	end
	// Ack spans the whole ninth clock; refuse stands for an absent charger
	always @(negedge scl) ack_oe = (nbit == 4'h8) && !refuse;
endmodule : charger_model
`default_nettype wire

// [verif/battery_capacity_gauge_tb.sv]
/* Bench for the capacity gauge: counting, thresholds, self-discharge, broadcasts.
   Assumes the package, the gauge, its link engine and the charger model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module battery_capacity_gauge_tb;
	import gauge_pkg::*;
	logic ref_clk, smb_clk, reset_n, chg_pulse, dsg_pulse, refuse, nv_save, vdf;
	logic scl_oe, sda_oe, ack_oe, nack_seen;
	logic [7:0] reg_cmd;
	logic [15:0] reg_rdata, nv_full_capacity, nbytes;
	logic [31:0] last4;
	logic [23:0] exp_cnt;
	gauge_cfg_t cfg;
	gauge_meas_t meas;
	int fail_count, total_checks, nv_saves;
	wire logic scl_w = ~scl_oe;
	wire logic sda_w = ~sda_oe & ~ack_oe;
	battery_capacity_gauge #(.TICKS_PER_SEC(20)) battery_capacity_gauge_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .smb_clk(smb_clk), .cfg(cfg), .meas(meas),
		.chg_pulse(chg_pulse), .dsg_pulse(dsg_pulse), .reg_cmd(reg_cmd),
		.reg_rdata(reg_rdata), .nv_save(nv_save), .nv_full_capacity(nv_full_capacity),
		.valid_discharge_flag(vdf), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .nack_seen(nack_seen));
	charger_model charger_model_inst (.scl(scl_w), .sda(sda_w), .refuse(refuse),
		.ack_oe(ack_oe), .last4(last4), .nbytes(nbytes));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// The save strobe stands one cycle, so it is counted where it is settled
	always @(negedge ref_clk) if (nv_save === 1'b1) nv_saves++;
	initial begin
		smb_clk = 1'b0;
		#3;
		forever #6 smb_clk = ~smb_clk;
	end
	task automatic close_out();
		if (fail_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tk
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		@(posedge ref_clk);
		reg_cmd <= c;
		repeat (2) @(negedge ref_clk);
		chk(reg_rdata, e);
		@(posedge ref_clk);
	endtask : rd
	task automatic cap();
		rd(8'h0f, exp_cnt[23:8]);
	endtask : cap
	// Pulses stay high and low long enough for the three-flop synchroniser
	task automatic pkt(input logic chg, input logic [23:0] amt);
		@(posedge ref_clk);
		if (chg) chg_pulse <= 1'b1;
		else dsg_pulse <= 1'b1;
		tk(3);
		chg_pulse <= 1'b0;
		dsg_pulse <= 1'b0;
		tk(6);
		exp_cnt = chg ? exp_cnt + amt : exp_cnt - amt;
	endtask : pkt
	task automatic sd_gap(input int gap);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			while (reg_rdata === exp_cnt[23:8] && n < 20000) begin
				@(negedge ref_clk);
				n++;
			end
			exp_cnt = exp_cnt - (exp_cnt >> 8);
			chk(reg_rdata, exp_cnt[23:8]);
		end
		chk({15'h0, n >= gap - 1 && n <= gap + 1}, 16'h1);
	endtask : sd_gap
	// The settle wait lets a frame latched from older values finish first
	task automatic frame(input logic [7:0] c, input logic [15:0] v);
		logic [15:0] n0;
		logic hit;
		hit = 1'b0;
		tk(300);
		n0 = nbytes;
		for (int n = 0; n < 900 && !hit; n++) begin
			@(negedge ref_clk);
			if (nbytes != n0 && last4[31:16] == {8'h12, c}) begin
				hit = 1'b1;
				chk({last4[7:0], last4[15:8]}, v);
			end
			n0 = nbytes;
		end
		chk({15'h0, hit}, 16'h1);
		@(posedge ref_clk);
	endtask : frame
	task automatic s_regs();
		rd(8'h0f, 16'h0000);
		rd(8'h0c, 16'h0064);
		rd(8'h10, 16'h07d0);
		rd(8'h0d, 16'h0000);
		rd(8'h55, 16'h0000);
	endtask : s_regs
	task automatic s_charge();
		repeat (4) pkt(1'b1, 24'h40);
		cap();
		meas.sense_uv <= 16'h0064;
		pkt(1'b1, 24'h0);
		cap();
		meas.sense_uv <= 16'h0190;
		cfg.integration_gain <= 16'h2000;
		cfg.chemistry_bit <= 1'b0;
		meas.temp_c <= 8'sh23;
		pkt(1'b1, 24'h1f5c);
		cap();
		meas.temp_c <= 8'sh2d;
		pkt(1'b1, 24'h1e66);
		cap();
		meas.temp_c <= 8'sh19;
		cfg.chemistry_bit <= 1'b1;
		repeat (2) pkt(1'b1, 24'h2000);
		cap();
		pkt(1'b1, 24'h1000);
		cap();
		rd(8'h0d, 16'h0007);
	endtask : s_charge
	task automatic s_hold();
		cfg.integration_gain <= 16'h8000;
		repeat (2) pkt(1'b1, 24'h4000);
		cap();
		cfg.integration_gain <= 16'h2000;
		pkt(1'b0, 24'h0ac2);
		cap();
		pkt(1'b0, 24'h0);
		cap();
		meas.voltage_mv <= 16'h0b54;
		tk(4);
		cap();
		pkt(1'b0, 24'h2000);
		cap();
		meas.voltage_mv <= 16'h0e10;
		cfg.integration_gain <= 16'h8000;
		pkt(1'b1, 24'h4000);
		meas.voltage_mv <= 16'h0b54;
		tk(4);
		exp_cnt = 24'h010400;
		cap();
	endtask : s_hold
	task automatic s_self();
		meas.discharging <= 1'b1;
		meas.temp_c <= 8'sh4b;
		sd_gap(32'h190);
		@(posedge ref_clk);
		meas.discharging <= 1'b0;
		tk(900);
		cap();
		meas.discharging <= 1'b1;
		meas.temp_c <= 8'sh41;
		sd_gap(32'h320);
		@(posedge ref_clk);
		meas.temp_c <= 8'sh19;
		sd_gap(32'h3200);
		@(posedge ref_clk);
		meas.discharging <= 1'b0;
		meas.voltage_mv <= 16'h0960;
		tk(4);
		exp_cnt = 24'h0;
		cap();
	endtask : s_self
	task automatic s_bcast();
		logic [15:0] n0;
		frame(8'h14, 16'h03e8);
		frame(8'h15, 16'h3a98);
		meas.current_ma <= 16'sh04e8;
		frame(8'h14, 16'h03e8);
		meas.current_ma <= 16'sh04e9;
		frame(8'h14, 16'h0000);
		frame(8'h16, 16'h4000);
		meas.current_ma <= 16'sh012c;
		frame(8'h14, 16'h0000);
		meas.current_ma <= 16'sh00c8;
		frame(8'h14, 16'h03e8);
		cfg.nominal_charge_current <= 16'h07d0;
		meas.current_ma <= 16'sh09c4;
		frame(8'h14, 16'h07d0);
		meas.current_ma <= 16'sh09c5;
		frame(8'h14, 16'h0000);
		meas.current_ma <= 16'sh0000;
		meas.battery_status <= 16'h1000;
		frame(8'h14, 16'h0000);
		frame(8'h16, 16'h1000);
		chk({15'h0, nack_seen}, 16'h0);
		meas.battery_status <= 16'h0000;
		cfg.charge_control_enable <= 1'b0;
		tk(300);
		n0 = nbytes;
		tk(600);
		chk(nbytes, n0);
		refuse <= 1'b1;
		cfg.charge_control_enable <= 1'b1;
		tk(900);
		chk({15'h0, nack_seen}, 16'h1);
	endtask : s_bcast
	task automatic s_learn();
		cfg.low_efficiency_factor <= 8'h64;
		cfg.integration_gain <= 16'hfa00;
		meas.voltage_mv <= 16'h0e10;
		repeat (8) pkt(1'b1, 24'h00fa00);
		cap();
		chk({15'h0, vdf}, 16'h1);
		repeat (6) pkt(1'b0, 24'h00fa00);
		meas.voltage_mv <= 16'h0b54;
		tk(4);
		exp_cnt = 24'h010400;
		cap();
		meas.voltage_mv <= 16'h0e10;
		cfg.integration_gain <= 16'h0a00;
		pkt(1'b1, 24'h000a00);
		rd(8'h10, 16'h06e0);
		rd(8'h0c, 16'h0002);
		chk(nv_full_capacity, 16'h06e0);
		chk(16'(nv_saves), 16'h0001);
		chk({15'h0, vdf}, 16'h0);
	endtask : s_learn
	initial begin
		tk(90000);
		fail_count++;
		close_out();
	end
	initial begin
		reset_n = 1'b0;
		chg_pulse = 1'b0;
		dsg_pulse = 1'b0;
		refuse = 1'b0;
		reg_cmd = 8'h0f;
		exp_cnt = 24'h0;
		cfg = '{16'h00fa, 16'h0040, 8'h05, 8'h64, 8'h32, 1'b1, 4'h0, 16'h0bb8, 16'h09c4,
			8'h0d, 1'b1, 16'h03e8, 16'h3a98};
		meas = '{16'h0190, 16'h0e10, 8'sh19, 16'sh0000, 1'b0, 1'b0, 16'h0000};
		tk(3);
		reset_n <= 1'b1;
		s_regs();
		s_charge();
		s_hold();
		s_self();
		s_bcast();
		s_learn();
		close_out();
	end
endmodule : battery_capacity_gauge_tb
`default_nettype wire
